/* File: rsi_cfg.svh */
// Register indices, bit positions, codes and vector addresses of the
// reset and interrupt source block.
// Assumes byte address = 4 * index on a 32-bit Avalon-MM slave.
`ifndef RSI_CFG_SVH
`define RSI_CFG_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define RSI_IDX_PCM0      6'h0F
`define RSI_IDX_PCM1      6'h10
`define RSI_IDX_CAUSE     6'h3B
`define RSI_IDX_SUPPLY    6'h3C
`define RSI_IDX_EXTCTL    6'h3D
`define RSI_IDX_FLAGS     6'h3E

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSI_B_SUPPLY_MONITOR_FLAG        7
`define RSI_B_SUPPLY_MONITOR_IRQ_ENABLE       6
`define RSI_B_WATCHDOG_RESET_CAUSE        3
`define RSI_B_PIN_RESET_CAUSE       1
`define RSI_B_POWER_ON_RESET_CAUSE        0
`define RSI_B_EXT_EN      4
`define RSI_B_PC0_EN      5
`define RSI_B_PC1_EN      6
`define RSI_B_F_EXT       0
`define RSI_B_F_PC0       1
`define RSI_B_F_PC1       2

// ----------------------------------------------------------------------
// Trigger level select codes
// ----------------------------------------------------------------------
`define RSI_SEL_OFF       3'h0
`define RSI_SEL_RST_LO    3'h1
`define RSI_SEL_RST_HI    3'h2
`define RSI_SEL_IRQ_MID   3'h3
`define RSI_SEL_IRQ_TOP   3'h4

// ----------------------------------------------------------------------
// Vector numbers, program address = vector number
// ----------------------------------------------------------------------
`define RSI_VEC_RESET     4'h0
`define RSI_VEC_EXT       4'h1
`define RSI_VEC_PC0       4'h2
`define RSI_VEC_PC1       4'h3
`define RSI_VEC_TCAP      4'h4
`define RSI_VEC_TOVF      4'h5
`define RSI_VEC_TCMA      4'h6
`define RSI_VEC_TCMB      4'h7
`define RSI_VEC_ACMP      4'h8
`define RSI_VEC_WDT       4'h9
`define RSI_VEC_VLM       4'hA
`define RSI_VEC_ADC       4'hB
`define RSI_VEC_RXS       4'hC
`define RSI_VEC_RXC       4'hD
`define RSI_VEC_DRE       4'hE
`define RSI_VEC_TXC       4'hF
`define RSI_VEC_HI_ZERO   8'h00

`endif

/* File: rsi_pkg.sv */
// Types shared by the reset and interrupt source block.
// Assumes rsi_cfg.svh for all numeric constants.
package rsi_pkg;
	typedef logic [7:0]  rsi_byte_t;
	typedef logic [11:0] rsi_addr_t;
	typedef enum logic [1:0] {
		RSI_SENSE_LOW,
		RSI_SENSE_ANY,
		RSI_SENSE_FALL,
		RSI_SENSE_RISE
	} rsi_sense_t;
endpackage

/* File: rsi_ext_sense.sv */
// Sense logic of the dedicated external interrupt pin.
// Assumes the pin is synchronous to sys_clk; edges need the clock running.
`timescale 1ns/10ps
`default_nettype none
`include "rsi_cfg.svh"

module rsi_ext_sense
	import rsi_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Pin and mode
	input  wire logic       pin,
	input  wire rsi_sense_t sense,
	// Results
	output logic            edge_hit,
	output logic            level_low
);
	logic pin_s_q;
	logic pin_p_q;
	wire  rise_w = pin_s_q & ~pin_p_q;
	wire  fall_w = ~pin_s_q & pin_p_q;

	// Pin is sampled, then edges compared between two samples
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_s_q <= 1'b1;
			pin_p_q <= 1'b1;
		end else begin
			pin_s_q <= pin;
			pin_p_q <= pin_s_q;
		end
	end

	always_comb begin
		case (sense)
			RSI_SENSE_ANY:  edge_hit = rise_w | fall_w;
			RSI_SENSE_FALL: edge_hit = fall_w;
			RSI_SENSE_RISE: edge_hit = rise_w;
			default:        edge_hit = 1'b0;
		endcase
	end

	assign level_low = ~pin_s_q;
endmodule // rsi_ext_sense
`default_nettype wire

/* File: rsi_top.sv */
// Reset and interrupt source block: supply monitor flag, reset causes,
// external and pin-change detection, vector selection for the core.
// Assumes synchronous inputs, one clock and an Avalon-MM master.
//
// How it works
// - Monitor flag set on trigger, cleared off/recovered
// - Enabled monitor raises request each flag set
// - Level 000 disables; codes 101-111 ignored
// - Codes 001/010 request reset, flag not set
// - Codes 011/100 set flag, maybe interrupt
// - Watchdog cause set by watchdog, POR/zero clear
// - Pin cause set by pin reset, POR/zero clear
// - Power-on cause cleared only by writing zero
// - Any reset starts execution at 0x000
// - External 0x001, change groups 0x002, 0x003
// - Timer sources vectored to 0x004-0x007
// - Comparator, watchdog, monitor, ADC at 0x008-0x00B
// - Serial sources vectored to 0x00C-0x00F
// - Pins sensed by level even as outputs
// - Any enabled masked pin toggle sets request
// - Pin change detected from clocked samples
// - External pin: falling, rising or held low
// - External edges need the running clock
// - Sense 00 low, 01 any, 10 fall, 11 rise
// - External and change flags clear on entry or write one
`timescale 1ns/10ps
`default_nettype none
`include "rsi_cfg.svh"

module rsi_top
	import rsi_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Reset causes from the reset sequencer
	input  wire logic        por_evt,
	input  wire logic        pin_rst_evt,
	input  wire logic        wdt_rst_evt,
	// Supply monitor comparator, high while supply is below the level
	input  wire logic        supply_below,
	// Pins, read back from the pad whatever its direction
	input  wire logic        dedicated_ext_irq_pin,
	input  wire logic [11:0] pin_change_inputs,
	// Peripheral requests: tcap tovf tcma tcmb acmp wdt adc rxs rxc dre txc
	input  wire logic [10:0] periph_irq,
	// Core side
	input  wire logic        irq_ack,
	output logic             irq_req,
	output var rsi_addr_t    irq_addr,
	output logic             supply_reset_req,
	output logic [2:0]       supply_level_sel
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [3:0] rsi_first(input logic [15:0] p);
		logic [3:0] v;
		v = `RSI_VEC_RESET;
		for (int i = 15; i > 0; i--) begin
			if (p[i]) begin
				v = 4'(i);
			end
		end
		return v;
	endfunction

	function automatic logic rsi_hit(input logic [7:0] a, input logic [5:0] idx);
		return a[7:2] == idx;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic        wait_q;
	logic [31:0] rdata_q;
	logic        watchdog_reset_cause_q, pin_reset_cause_q, power_on_reset_cause_q;
	logic [2:0]  sel_q;
	logic        supply_monitor_irq_enable_q, supply_monitor_flag_q, vlm_pend_q;
	logic [1:0]  sense_q;
	logic        ext_en_q;
	logic [1:0]  pc_en_q;
	logic        ext_flag_q;
	logic [1:0]  pc_flag_q;
	logic [7:0]  pcm0_q;
	logic [3:0]  pcm1_q;
	logic [11:0] pc_s_q, pc_p_q;
	logic        rst_req_q, irq_req_q;
	rsi_addr_t   irq_addr_q;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire       wr_w     = avs_write & ~wait_q;
	wire [7:0] wd_w     = avs_writedata[7:0];
	wire       wr_cause = wr_w & rsi_hit(avs_address, `RSI_IDX_CAUSE);
	wire       wr_sup   = wr_w & rsi_hit(avs_address, `RSI_IDX_SUPPLY);
	wire       wr_ctl   = wr_w & rsi_hit(avs_address, `RSI_IDX_EXTCTL);
	wire       wr_flg   = wr_w & rsi_hit(avs_address, `RSI_IDX_FLAGS);
	wire       wr_m0    = wr_w & rsi_hit(avs_address, `RSI_IDX_PCM0);
	wire       wr_m1    = wr_w & rsi_hit(avs_address, `RSI_IDX_PCM1);
	wire       sel_ok   = wd_w[2:0] <= `RSI_SEL_IRQ_TOP;

	// ------------------------------------------------------------------
	// Supply monitor
	// ------------------------------------------------------------------
	wire sel_off  = sel_q == `RSI_SEL_OFF;
	wire sel_rst  = (sel_q == `RSI_SEL_RST_LO) | (sel_q == `RSI_SEL_RST_HI);
	wire sel_irq  = (sel_q == `RSI_SEL_IRQ_MID) | (sel_q == `RSI_SEL_IRQ_TOP);
	wire supply_monitor_flag_d   = (sel_off | ~supply_below) ? 1'b0 :
	                (sel_irq ? 1'b1 : supply_monitor_flag_q);
	wire vlm_rise = supply_monitor_flag_d & ~supply_monitor_flag_q;

	// ------------------------------------------------------------------
	// External pin and pin change
	// ------------------------------------------------------------------
	logic ext_edge, ext_low;
	rsi_ext_sense u_sense (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pin       (dedicated_ext_irq_pin),
		.sense     (rsi_sense_t'(sense_q)),
		.edge_hit  (ext_edge),
		.level_low (ext_low)
	);
	wire        lvl_mode = rsi_sense_t'(sense_q) == RSI_SENSE_LOW;
	wire [11:0] pc_tgl   = (pc_s_q ^ pc_p_q) & {pcm1_q, pcm0_q};
	wire [1:0]  pc_chg   = {|pc_tgl[11:8], |pc_tgl[7:0]};
	wire [3:0]  ack_v    = irq_addr_q[3:0];
	wire        ack_ext  = irq_ack & (ack_v == `RSI_VEC_EXT);
	wire        ack_pc0  = irq_ack & (ack_v == `RSI_VEC_PC0);
	wire        ack_pc1  = irq_ack & (ack_v == `RSI_VEC_PC1);
	wire        ack_vlm  = irq_ack & (ack_v == `RSI_VEC_VLM);

	// Set wins over clear by entry or write-one
	wire       ext_flag_d = lvl_mode ? 1'b0 :
	                        (ext_edge | (ext_flag_q & ~ack_ext &
	                        ~(wr_flg & wd_w[`RSI_B_F_EXT])));
	wire [1:0] pc_flag_d  = pc_chg | (pc_flag_q & ~{ack_pc1, ack_pc0} &
	                        ~({2{wr_flg}} & wd_w[`RSI_B_F_PC1:`RSI_B_F_PC0]));
	wire       vlm_pend_d = (vlm_rise & supply_monitor_irq_enable_q) | (vlm_pend_q & ~ack_vlm);

	// ------------------------------------------------------------------
	// Vector selection
	// ------------------------------------------------------------------
	wire ext_req = ext_en_q & (lvl_mode ? ext_low : ext_flag_d);
	wire [15:0] pend_w = {
		periph_irq[10:6],
		vlm_pend_d,
		periph_irq[5:0],
		pc_en_q & pc_flag_d,
		ext_req,
		1'b0
	};
	wire [3:0] first_w = rsi_first(pend_w);

	// ------------------------------------------------------------------
	// Bus answer: one wait cycle, read data and writes at the second edge
	// ------------------------------------------------------------------
	logic [7:0] rmux;
	always_comb begin
		rmux = 8'h00;
		case (avs_address[7:2])
			`RSI_IDX_CAUSE:  rmux = {4'h0, watchdog_reset_cause_q, 1'b0, pin_reset_cause_q, power_on_reset_cause_q};
			`RSI_IDX_SUPPLY: rmux = {supply_monitor_flag_q, supply_monitor_irq_enable_q, 3'h0, sel_q};
			`RSI_IDX_EXTCTL: rmux = {1'b0, pc_en_q, ext_en_q, 2'h0, sense_q};
			`RSI_IDX_FLAGS:  rmux = {5'h00, pc_flag_q, ext_flag_q};
			`RSI_IDX_PCM0:   rmux = pcm0_q;
			`RSI_IDX_PCM1:   rmux = {4'h0, pcm1_q};
			default:         rmux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~((avs_read | avs_write) & wait_q);
			if (avs_read & wait_q) begin
				rdata_q <= {24'h00_0000, rmux};
			end
		end
	end

	// ------------------------------------------------------------------
	// Reset cause flags; a low rst_n acts as power-on
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			power_on_reset_cause_q  <= 1'b1;
			watchdog_reset_cause_q  <= 1'b0;
			pin_reset_cause_q <= 1'b0;
		end else begin
			power_on_reset_cause_q  <= por_evt | (power_on_reset_cause_q & ~(wr_cause & ~wd_w[`RSI_B_POWER_ON_RESET_CAUSE]));
			watchdog_reset_cause_q  <= wdt_rst_evt | (watchdog_reset_cause_q & ~por_evt &
			           ~(wr_cause & ~wd_w[`RSI_B_WATCHDOG_RESET_CAUSE]));
			pin_reset_cause_q <= pin_rst_evt | (pin_reset_cause_q & ~por_evt &
			           ~(wr_cause & ~wd_w[`RSI_B_PIN_RESET_CAUSE]));
		end
	end

	// ------------------------------------------------------------------
	// Control registers and flags
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sel_q      <= `RSI_SEL_OFF;
			supply_monitor_irq_enable_q    <= 1'b0;
			supply_monitor_flag_q     <= 1'b0;
			vlm_pend_q <= 1'b0;
			sense_q    <= 2'h0;
			ext_en_q   <= 1'b0;
			pc_en_q    <= 2'h0;
			ext_flag_q <= 1'b0;
			pc_flag_q  <= 2'h0;
			pcm0_q     <= 8'h00;
			pcm1_q     <= 4'h0;
		end else begin
			if (wr_sup) begin
				supply_monitor_irq_enable_q <= wd_w[`RSI_B_SUPPLY_MONITOR_IRQ_ENABLE];
				if (sel_ok) begin
					sel_q <= wd_w[2:0];
				end
			end
			if (wr_ctl) begin
				sense_q  <= wd_w[1:0];
				ext_en_q <= wd_w[`RSI_B_EXT_EN];
				pc_en_q  <= {wd_w[`RSI_B_PC1_EN], wd_w[`RSI_B_PC0_EN]};
			end
			if (wr_m0) begin
				pcm0_q <= wd_w;
			end
			if (wr_m1) begin
				pcm1_q <= wd_w[3:0];
			end
			supply_monitor_flag_q     <= supply_monitor_flag_d;
			vlm_pend_q <= vlm_pend_d;
			ext_flag_q <= ext_flag_d;
			pc_flag_q  <= pc_flag_d;
		end
	end

	// ------------------------------------------------------------------
	// Pin-change samples and core requests
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pc_s_q     <= 12'h000;
			pc_p_q     <= 12'h000;
			rst_req_q  <= 1'b0;
			irq_req_q  <= 1'b0;
			irq_addr_q <= {`RSI_VEC_HI_ZERO, `RSI_VEC_RESET};
		end else begin
			pc_s_q     <= pin_change_inputs;
			pc_p_q     <= pc_s_q;
			rst_req_q  <= sel_rst & supply_below;
			irq_req_q  <= |pend_w;
			irq_addr_q <= {`RSI_VEC_HI_ZERO, first_w};
		end
	end

	assign avs_waitrequest  = wait_q;
	assign avs_readdata     = rdata_q;
	assign irq_req          = irq_req_q;
	assign irq_addr         = irq_addr_q;
	assign supply_reset_req = rst_req_q;
	assign supply_level_sel = sel_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_supply_monitor_flag_off;
		sel_off |=> !supply_monitor_flag_q;
	endproperty
	a_supply_monitor_flag_off: assert property (p_supply_monitor_flag_off) else $error("monitor flag set while off");

	property p_vlm_irq;
		$rose(supply_monitor_flag_q) && $past(supply_monitor_irq_enable_q) |-> vlm_pend_q && irq_req_q;
	endproperty
	a_vlm_irq: assert property (p_vlm_irq) else $error("monitor request missing");

	property p_sel_legal;
		sel_q <= `RSI_SEL_IRQ_TOP;
	endproperty
	a_sel_legal: assert property (p_sel_legal) else $error("illegal level code held");

	property p_vlm_reset;
		sel_rst && supply_below && !wr_sup |=> supply_reset_req && !supply_monitor_flag_q;
	endproperty
	a_vlm_reset: assert property (p_vlm_reset) else $error("level reset not raised");

	property p_vlm_set;
		sel_irq && supply_below |=> supply_monitor_flag_q;
	endproperty
	a_vlm_set: assert property (p_vlm_set) else $error("monitor flag not set");

	property p_wd_cause;
		wdt_rst_evt |=> watchdog_reset_cause_q;
	endproperty
	a_wd_cause: assert property (p_wd_cause) else $error("watchdog cause not set");

	property p_pin_cause;
		pin_rst_evt ##1 (!por_evt && !wr_cause)[*2] |-> pin_reset_cause_q;
	endproperty
	a_pin_cause: assert property (p_pin_cause) else $error("pin cause lost");

	property p_por_keep;
		power_on_reset_cause_q && !(wr_cause && !wd_w[`RSI_B_POWER_ON_RESET_CAUSE]) |=> power_on_reset_cause_q;
	endproperty
	a_por_keep: assert property (p_por_keep) else $error("power-on cause lost");

	property p_pc_flag;
		pc_chg[0] |=> pc_flag_q[0];
	endproperty
	a_pc_flag: assert property (p_pc_flag) else $error("pin change missed");

	property p_level;
		ext_en_q && lvl_mode && ext_low && !wr_ctl |=> irq_req_q && irq_addr_q[3:0] <= `RSI_VEC_EXT;
	endproperty
	a_level: assert property (p_level) else $error("low level not requested");

	property p_ext_vec;
		ext_en_q && ext_edge |=> irq_req_q && irq_addr_q[3:0] == `RSI_VEC_EXT;
	endproperty
	a_ext_vec: assert property (p_ext_vec) else $error("edge request not vectored");

	property p_ext_clear;
		wr_flg && wd_w[`RSI_B_F_EXT] && !ext_edge |=> !ext_flag_q;
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("pin flag not cleared");

	property p_pc_entry;
		ack_pc0 && !pc_chg[0] |=> !pc_flag_q[0];
	endproperty
	a_pc_entry: assert property (p_pc_entry) else $error("change flag kept on entry");
endmodule // rsi_top
`default_nettype wire

/* File: rsi_core_model.sv */
// Behavioural processor core that enters the vector shown on the interrupt link.
// Assumes registered irq_req/irq_addr that settle one edge after an ack.
`timescale 1ns/10ps
`default_nettype none

module rsi_core_model
	import rsi_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Bench control
	input  wire logic       take_en,
	input  wire logic [1:0] ack_delay,
	// Interrupt link
	input  wire logic       irq_req,
	input  wire rsi_addr_t  irq_addr,
	output logic            irq_ack
);
	logic [1:0] wait_q;
	logic [1:0] gap_q;

	// Acks after a delay, then lets the request settle before looking again
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_ack <= 1'b0;
			wait_q  <= 2'h0;
			gap_q   <= 2'h0;
		end else begin
			irq_ack <= 1'b0;
			if (gap_q != 2'h0) begin
				gap_q <= gap_q - 2'h1;
			end else if (take_en && irq_req && wait_q >= ack_delay) begin
				irq_ack <= 1'b1;
				wait_q  <= 2'h0;
				gap_q   <= 2'h3;
			end else begin
				wait_q <= (take_en && irq_req) ? wait_q + 2'h1 : 2'h0;
			end
		end
	end
endmodule // rsi_core_model
`default_nettype wire

/* File: rsi_top_tb.sv */
// Self-checking bench of the reset and interrupt source block.
// Assumes rsi_top, rsi_core_model and an Avalon-MM slave with one wait cycle.
`timescale 1ns/10ps
`default_nettype none
`include "rsi_cfg.svh"

module rsi_top_tb
	import rsi_pkg::*;
;
	logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address, rd, m0, m1, f;
	logic [31:0] avs_writedata, avs_readdata;
	logic        por_evt, pin_rst_evt, wdt_rst_evt, supply_below, ext_pin;
	logic        irq_ack, irq_req, sup_rst, take_en;
	logic [11:0] pcin, tog, e;
	logic [10:0] periph;
	logic [2:0]  sup_sel;
	logic [1:0]  ack_dly;
	rsi_addr_t   irq_addr;
	rsi_addr_t   taken_q[$];
	int          bad_count, compares, lv;

	rsi_top rsi_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .por_evt(por_evt),
		.pin_rst_evt(pin_rst_evt), .wdt_rst_evt(wdt_rst_evt), .supply_below(supply_below),
		.dedicated_ext_irq_pin(ext_pin), .pin_change_inputs(pcin), .periph_irq(periph),
		.irq_ack(irq_ack), .irq_req(irq_req), .irq_addr(irq_addr),
		.supply_reset_req(sup_rst), .supply_level_sel(sup_sel));
	rsi_core_model rsi_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .take_en(take_en),
		.ack_delay(ack_dly), .irq_req(irq_req), .irq_addr(irq_addr), .irq_ack(irq_ack));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Vectors entered by the core, in order
	always @(posedge sys_clk) if (irq_ack === 1'b1) taken_q.push_back(irq_addr);
	initial begin
		repeat (100000) @(posedge sys_clk);
		$display("ERROR run expected finish seen timeout");
		bad_count++;
		end_of_test();
	end

	// ----
	// Tasks
	// ----
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		compares++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address   <= {idx, 2'b00};
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= {24'h000000, wd};
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			$display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
			bad_count++;
			end_of_test();
		end
		rd = avs_readdata[7:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rchk(input string name, input logic [5:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(name, {4'h0, exp}, {4'h0, rd});
	endtask
	task automatic evt(input logic [2:0] ev);
		@(posedge sys_clk);
		{por_evt, pin_rst_evt, wdt_rst_evt} <= ev;
		@(posedge sys_clk);
		{por_evt, pin_rst_evt, wdt_rst_evt} <= 3'h0;
	endtask
	task automatic take(input int n);
		int k;
		taken_q.delete();
		@(posedge sys_clk);
		take_en <= 1'b1;
		ack_dly <= 2'($urandom);
		for (k = 0; k < 200 && taken_q.size() < n; k++) @(posedge sys_clk);
		take_en <= 1'b0;
		if (k == 200) begin
			$display("ERROR acks expected %0d seen %0d", n, taken_q.size());
			bad_count++;
			end_of_test();
		end
		step(4);
	endtask
	function automatic logic [11:0] vec_of(input int i);
		return (i < 5) ? 12'(i + 4) : (i == 5) ? 12'h009 : 12'(i + 5);
	endfunction

	// ----
	// Main sequence
	// ----
	initial begin
		rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
		avs_writedata = 32'h0; {por_evt, pin_rst_evt, wdt_rst_evt} = 3'h0;
		supply_below = 1'b0; ext_pin = 1'b1; pcin = 12'h000; periph = 11'h000;
		take_en = 1'b0; ack_dly = 2'h0; bad_count = 0; compares = 0;
		void'($urandom(32'h3054));
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		step(1);
		chk("irq_addr", 12'h000, irq_addr);
		chk("irq_req", 12'h000, {11'h0, irq_req});
		rchk("cause", `RSI_IDX_CAUSE, 8'h01);
		rchk("supply", `RSI_IDX_SUPPLY, 8'h00);
		$display("Test reset done");
		evt(3'b011);
		rchk("cause", `RSI_IDX_CAUSE, 8'h0B);
		bus(1'b1, `RSI_IDX_CAUSE, 8'hF5);
		rchk("cause", `RSI_IDX_CAUSE, 8'h01);
		evt(3'b001);
		rchk("cause", `RSI_IDX_CAUSE, 8'h09);
		evt(3'b100);
		rchk("cause", `RSI_IDX_CAUSE, 8'h01);
		bus(1'b1, `RSI_IDX_CAUSE, 8'h00);
		evt(3'b011);
		rchk("cause", `RSI_IDX_CAUSE, 8'h0A);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rchk("cause", `RSI_IDX_CAUSE, 8'h01);
		chk("irq_addr", 12'h000, irq_addr);
		$display("Test reset causes done");
		m0 = 8'($urandom);
		m1 = 8'($urandom);
		bus(1'b1, `RSI_IDX_PCM0, m0);
		bus(1'b1, `RSI_IDX_PCM1, m1);
		bus(1'b1, 6'h20, 8'hFF);
		rchk("mask0", `RSI_IDX_PCM0, m0);
		rchk("mask1", `RSI_IDX_PCM1, m1 & 8'h0F);
		rchk("unmapped", 6'h20, 8'h00);
		$display("Test registers done");
		@(posedge sys_clk);
		supply_below <= 1'b1;
		lv = 0;
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, `RSI_IDX_SUPPLY, {5'b01000, 3'(c)});
			if (c < 5) lv = c;
			step(3);
			chk("level", 12'(lv), {9'h0, sup_sel});
			chk("reset_req", 12'(lv == 1 || lv == 2), {11'h0, sup_rst});
			rchk("supply", `RSI_IDX_SUPPLY, {lv == 3 || lv == 4, 4'h8, 3'(lv)});
		end
		chk("vector", 12'h00A, irq_addr);
		take(1);
		chk("entered", 12'h00A, taken_q[0]);
		chk("irq_req", 12'h000, {11'h0, irq_req});
		@(posedge sys_clk);
		supply_below <= 1'b0;
		rchk("supply", `RSI_IDX_SUPPLY, 8'h44);
		@(posedge sys_clk);
		supply_below <= 1'b1;
		step(3);
		chk("vector", 12'h00A, irq_addr);
		bus(1'b1, `RSI_IDX_SUPPLY, 8'h40);
		rchk("supply", `RSI_IDX_SUPPLY, 8'h40);
		take(1);
		chk("irq_req", 12'h000, {11'h0, irq_req});
		$display("Test supply monitor done");
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, `RSI_IDX_EXTCTL, 8'h10 | 8'(m));
			bus(1'b1, `RSI_IDX_FLAGS, 8'h07);
			@(posedge sys_clk);
			ext_pin <= 1'b0;
			step(3);
			chk("ext_req", 12'(m != 3), {11'h0, irq_req});
			rchk("ext_fall", `RSI_IDX_FLAGS, 8'(m == 1 || m == 2));
			bus(1'b1, `RSI_IDX_FLAGS, 8'h01);
			step(2);
			chk("ext_hold", 12'(m == 0), {11'h0, irq_req});
			@(posedge sys_clk);
			ext_pin <= 1'b1;
			step(3);
			if (m == 1 || m == 3) chk("ext_vec", 12'h001, irq_addr);
			rchk("ext_rise", `RSI_IDX_FLAGS, 8'(m == 1 || m == 3));
			bus(1'b1, `RSI_IDX_FLAGS, 8'h07);
		end
		$display("Test external pin done");
		bus(1'b1, `RSI_IDX_EXTCTL, 8'h60);
		repeat (8) begin
			tog = 12'($urandom);
			@(posedge sys_clk);
			pcin <= pcin ^ tog;
			step(3);
			f = {5'h0, |(tog[11:8] & m1[3:0]), |(tog[7:0] & m0), 1'b0};
			chk("pc_vec", f[1] ? 12'h002 : f[2] ? 12'h003 : 12'h000, irq_addr);
			rchk("pc_flags", `RSI_IDX_FLAGS, f);
			bus(1'b1, `RSI_IDX_FLAGS, 8'h07);
		end
		bus(1'b1, `RSI_IDX_PCM0, 8'hFF);
		bus(1'b1, `RSI_IDX_PCM1, 8'h0F);
		@(posedge sys_clk);
		pcin <= pcin ^ 12'h101;
		step(3);
		take(2);
		chk("entered", 12'h002, taken_q[0]);
		chk("entered", 12'h003, taken_q[1]);
		rchk("pc_flags", `RSI_IDX_FLAGS, 8'h00);
		$display("Test pin change done");
		for (int i = 0; i < 11; i++) begin
			@(posedge sys_clk);
			periph <= 11'h001 << i;
			step(2);
			chk("vector", vec_of(i), irq_addr);
		end
		repeat (6) begin
			@(posedge sys_clk);
			periph <= 11'($urandom) | 11'h400;
			step(2);
			for (int i = 10; i >= 0; i--) if (periph[i]) e = vec_of(i);
			chk("vector", e, irq_addr);
		end
		@(posedge sys_clk);
		periph <= 11'h7FF;
		pcin   <= pcin ^ 12'h001;
		step(3);
		chk("vector", 12'h002, irq_addr);
		bus(1'b1, `RSI_IDX_FLAGS, 8'h07);
		step(2);
		chk("vector", 12'h004, irq_addr);
		@(posedge sys_clk);
		periph <= 11'h000;
		step(2);
		chk("irq_req", 12'h000, {11'h0, irq_req});
		$display("Test vectors done");
		end_of_test();
	end
endmodule // rsi_top_tb
`default_nettype wire
